// File: smr_pkg.sv
// Purpose: constants for the stop mode recovery controller
// Assumes: one clock, core_clk, standing for the internal oscillator
// Notes:   counts are in internal oscillator cycles
//
// Overview of operation
// - Executing a stop instruction puts the device into the stop state.
// - Recovery holds the processor in reset 67 cycles without crystal, 5001 with crystal.
// - The recovery hold already covers internal oscillator start-up, nothing is added.
// - Recovery changes only the watchdog control and oscillator control state.
// - After any recovery the internal oscillator is enabled and selected as clock.
// - Leaving reset, the processor fetches its vector from 0002H and 0003H and runs there.
// - The stop flag reads 1 after a recovery; with the timeout flag it marks a watchdog cause.
// - The stop flag clears on power-on reset or a watchdog time-out outside stop.
// - Reading the status clears the stop, watchdog timeout and external reset flags.
// - The timeout flag sets on a time-out and clears on power-on reset or pin recovery.
// - The external reset flag sets on a pin reset and clears on power-on or pin recovery.
// - Each pin enable bit lets any transition on its pin during stop start recovery.
// - A resetting watchdog time-out in stop starts recovery and sets timeout and stop flags.
package smr_pkg;
  localparam int          CLK_PERIOD_NS     = 5;
  localparam int          HOLD_NO_XTAL      = 66;
  localparam int          HOLD_XTAL         = 5000;
  localparam int          CNT_W             = 13;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;
  localparam logic [2:0]  STATUS_RESET      = 3'h0;
  localparam logic        OSC_SEL_INTERNAL  = 1'h0;

  typedef enum logic [1:0]
  {
    SMR_RUN     = 2'b00,
    SMR_STOP    = 2'b01,
    SMR_HOLD    = 2'b11,
    SMR_RELEASE = 2'b10
  } smr_state_type;
endpackage

// File: smr_hold_counter.sv
// Purpose: recovery hold counter
// Assumes: load and count are exclusive
// Notes:   done pulses when the count reaches zero
`timescale 1ns/1ps
module smr_hold_counter
  import smr_pkg::*;
#(
  parameter int WIDTH = CNT_W
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             count_en,
  output logic                  done
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_done;

  always_comb
  begin
    next_count = count;
    next_done  = 1'b0;
    if (load)
    begin
      next_count = load_value;
    end
    else if (count_en && count != '0)
    begin
      next_count = count - WIDTH'(1);
      next_done  = (count == WIDTH'(1));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done  <= next_done;
    end
  end
endmodule

// File: smr_wake_detect.sv
// Purpose: per-pin wake transition detector
// Assumes: pins synchronous to core_clk
// Notes:   registered wake pulse
`timescale 1ns/1ps
module smr_wake_detect
#(
  parameter int PINS = 8
)
(
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic [PINS-1:0] port_pins,
  input  wire logic [PINS-1:0] pin_recovery_source_enable,
  input  wire logic            armed,
  output logic                 wake
);
  logic [PINS-1:0] last_pins;
  logic [PINS-1:0] hit;
  logic            next_wake;

  genvar i;
  generate
    for (i = 0; i < PINS; i++)
    begin : g_pin
      assign hit[i] = pin_recovery_source_enable[i] & (port_pins[i] ^ last_pins[i]);
    end
  endgenerate

  always_comb
  begin
    next_wake = armed & (|hit);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_pins <= '0;
      wake      <= 1'b0;
    end
    else
    begin
      last_pins <= port_pins;
      wake      <= next_wake;
    end
  end
endmodule

// File: stop_mode_recovery_ctrl.sv
// Purpose: stop state entry, recovery hold and reset cause flags
// Assumes: core_clk is the internal oscillator; rst_n is power-on reset
// Notes:   status reads clear flags, hardware sets win
`timescale 1ns/1ps
module stop_mode_recovery_ctrl
  import smr_pkg::*;
#(
  parameter int PINS     = 8,
  parameter int HOLD_XT  = HOLD_XTAL,
  parameter int HOLD_INT = HOLD_NO_XTAL
)
(
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            stop_instr,
  input  wire logic            xtal_enabled,
  input  wire logic [PINS-1:0] port_pins,
  input  wire logic [PINS-1:0] pin_recovery_source_enable,
  input  wire logic            watchdog_timeout,
  input  wire logic            watchdog_reset_en,
  input  wire logic            ext_reset_event,
  input  wire logic            status_read,
  output logic                 stop_active,
  output logic                 cpu_reset,
  output logic                 fetch_vector,
  output logic [15:0]          vector_addr,
  output logic                 internal_oscillator_enable,
  output logic                 osc_select,
  output logic                 watchdog_reset_req,
  output logic                 stop_flag,
  output logic                 watchdog_timeout_flag,
  output logic                 external_reset_flag
);
  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  smr_state_type    state;
  smr_state_type    next_state;
  logic             pin_wake;
  logic             hold_done;
  logic             load_hold;
  logic [CNT_W-1:0] hold_value;
  logic             wdt_in_stop;
  logic             pin_cause;
  logic             next_cpu_reset;
  logic             next_fetch;
  logic             next_osc_en;
  logic             next_osc_sel;
  logic             next_wdt_req;
  logic             next_stop_flag;
  logic             next_wdt_flag;
  logic             next_ext_flag;

  assign wdt_in_stop = (state == SMR_STOP) && watchdog_timeout && watchdog_reset_en;
  assign pin_cause   = (state == SMR_STOP) && pin_wake && !wdt_in_stop;
  assign load_hold   = pin_cause || wdt_in_stop;

  assign hold_value = xtal_enabled ? CNT_W'(HOLD_XT) : CNT_W'(HOLD_INT);

  smr_wake_detect #(.PINS(PINS)) u_wake
  (
    .core_clk                   (core_clk),
    .rst_n                      (rst_n),
    .port_pins                  (port_pins),
    .pin_recovery_source_enable (pin_recovery_source_enable),
    .armed                      (state == SMR_STOP),
    .wake                       (pin_wake)
  );

  smr_hold_counter #(.WIDTH(CNT_W)) u_hold
  (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .load       (load_hold),
    .load_value (hold_value),
    .count_en   (state == SMR_HOLD),
    .done       (hold_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_cpu_reset = 1'b0;
    next_fetch     = 1'b0;
    next_osc_en    = internal_oscillator_enable;
    next_osc_sel   = osc_select;
    next_wdt_req   = 1'b0;
    unique case (state)
      SMR_RUN:
      begin
        if (stop_instr)
        begin
          next_state = SMR_STOP;
        end
        next_wdt_req = watchdog_timeout && watchdog_reset_en;
      end
      SMR_STOP:
      begin
        if (load_hold)
        begin
          next_state     = SMR_HOLD;
          next_cpu_reset = 1'b1;
        end
      end
      SMR_HOLD:
      begin
        next_cpu_reset = 1'b1;
        if (hold_done)
        begin
          next_state     = SMR_RELEASE;
          next_cpu_reset = 1'b0;
          next_fetch     = 1'b1;
          next_osc_en    = 1'b1;
          next_osc_sel   = OSC_SEL_INTERNAL;
        end
      end
      SMR_RELEASE:
      begin
        next_state = SMR_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                      <= SMR_RUN;
      cpu_reset                  <= 1'b0;
      fetch_vector               <= 1'b0;
      internal_oscillator_enable <= 1'b1;
      osc_select                 <= OSC_SEL_INTERNAL;
      watchdog_reset_req         <= 1'b0;
      stop_active                <= 1'b0;
      vector_addr                <= RESET_VECTOR_ADDR;
    end
    else
    begin
      state                      <= next_state;
      cpu_reset                  <= next_cpu_reset;
      fetch_vector               <= next_fetch;
      internal_oscillator_enable <= next_osc_en;
      osc_select                 <= next_osc_sel;
      watchdog_reset_req         <= next_wdt_req;
      stop_active                <= (next_state == SMR_STOP);
      vector_addr                <= RESET_VECTOR_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // cause flags
  // ----------------------------------------------------------------
  // only flag state touched
  always_comb
  begin
    next_stop_flag = stop_flag;
    next_wdt_flag  = watchdog_timeout_flag;
    next_ext_flag  = external_reset_flag;
    if (status_read)
    begin
      next_stop_flag = 1'b0;
      next_wdt_flag  = 1'b0;
      next_ext_flag  = 1'b0;
    end
    if (pin_cause)
    begin
      next_wdt_flag = 1'b0;
      next_ext_flag = 1'b0;
    end
    if (watchdog_timeout && state != SMR_STOP)
    begin
      next_stop_flag = 1'b0;
    end
    if (load_hold)
    begin
      next_stop_flag = 1'b1;
    end
    if (watchdog_timeout)
    begin
      next_wdt_flag = 1'b1;
    end
    if (ext_reset_event)
    begin
      next_ext_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_flag             <= STATUS_RESET[0];
      watchdog_timeout_flag <= STATUS_RESET[1];
      external_reset_flag   <= STATUS_RESET[2];
    end
    else
    begin
      stop_flag             <= next_stop_flag;
      watchdog_timeout_flag <= next_wdt_flag;
      external_reset_flag   <= next_ext_flag;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_stop_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMR_RUN && stop_instr) |=> stop_active)
    else $error("stop not entered");

  a_hold_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMR_HOLD && !hold_done) |=> cpu_reset)
    else $error("reset dropped during hold");

  a_hold_short: assert property (@(posedge core_clk) disable iff (!rst_n)
    (load_hold && !xtal_enabled) |=> cpu_reset [*8])
    else $error("hold too short");

  a_osc_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(fetch_vector) |-> internal_oscillator_enable && osc_select == OSC_SEL_INTERNAL)
    else $error("oscillator not internal after recovery");

  a_vector_fetch: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(cpu_reset) |-> fetch_vector && vector_addr == RESET_VECTOR_ADDR)
    else $error("no vector fetch on release");

  a_stop_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    load_hold |=> stop_flag)
    else $error("stop flag not set");

  a_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (status_read && !watchdog_timeout && !ext_reset_event && !load_hold)
      |=> !stop_flag && !watchdog_timeout_flag && !external_reset_flag)
    else $error("read did not clear flags");

  a_wdt_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    watchdog_timeout |=> watchdog_timeout_flag)
    else $error("timeout flag not set");

  a_pin_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pin_cause && !ext_reset_event) |=> !external_reset_flag)
    else $error("external flag not cleared by pin recovery");

  a_wdt_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    wdt_in_stop |=> state == SMR_HOLD && stop_flag && watchdog_timeout_flag)
    else $error("watchdog stop recovery wrong");

  a_release_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    hold_done |=> !cpu_reset && state == SMR_RELEASE)
    else $error("release not after count");

  a_stop_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMR_STOP && stop_instr && !load_hold) |=> state == SMR_STOP && !cpu_reset)
    else $error("repeated stop disturbed stop state");

  a_fetch_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    fetch_vector |=> !fetch_vector)
    else $error("vector fetch longer than one cycle");

  a_hold_long: assert property (@(posedge core_clk) disable iff (!rst_n)
    (load_hold && xtal_enabled) |=> cpu_reset [*8])
    else $error("crystal hold too short");

  a_ext_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_reset_event |=> external_reset_flag)
    else $error("external flag not set");

  a_stop_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (watchdog_timeout && state != SMR_STOP) |=> !stop_flag)
    else $error("stop flag not cleared by time-out");

  a_wdt_pin_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pin_cause && !watchdog_timeout) |=> !watchdog_timeout_flag)
    else $error("timeout flag not cleared by pin recovery");

  a_pin_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_cause |=> state == SMR_HOLD && cpu_reset)
    else $error("pin wake did not start hold");

  a_stop_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMR_STOP && !load_hold) |=> stop_active)
    else $error("stop left without wake");

  a_wdt_req: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMR_RUN && watchdog_timeout && watchdog_reset_en) |=> watchdog_reset_req)
    else $error("no watchdog reset outside stop");

  a_release_run: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMR_RELEASE) |=> state == SMR_RUN)
    else $error("release not followed by run");
endmodule

// File: smr_core_model.sv
// Purpose: processor core and wake pin model for the stop recovery bench
// Assumes: drives stop_instr, status_read and port_pins just after the falling edge
// Notes:   records the vector address seen at reset release
`timescale 1ns/1ps
module smr_core_model
(
  input  wire logic        core_clk,
  input  wire logic        fetch_vector,
  input  wire logic [15:0] vector_addr,
  output logic             stop_instr,
  output logic             status_read,
  output logic [7:0]       port_pins,
  output logic [15:0]      fetched_addr
);
  initial
  begin
    stop_instr = 1'h0;
    status_read = 1'h0;
    port_pins = 8'h5a;
    fetched_addr = 16'hffff;
  end

  // ----------------------------------------
  // core behaviour
  // ----------------------------------------
  // vector fetch capture
  always @(posedge core_clk)
    fetched_addr <= (fetch_vector === 1'b1) ? vector_addr : 16'hffff;

  task automatic exec_stop();
    @(negedge core_clk) stop_instr = 1'h1;
    @(negedge core_clk) stop_instr = 1'h0;
  endtask

  // oscillator left as recovery forced it
  task automatic read_status();
    @(negedge core_clk) status_read = 1'h1;
    @(negedge core_clk) status_read = 1'h0;
  endtask

  task automatic toggle_pin(input int p);
    @(negedge core_clk) port_pins[p] = ~port_pins[p];
  endtask
endmodule

// File: stop_mode_recovery_ctrl_tb.sv
// Purpose: self-checking bench for the stop mode recovery controller
// Assumes: short crystal hold count of 20
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module stop_mode_recovery_ctrl_tb;
  import smr_pkg::*;
  localparam int HX = 20;
  logic core_clk = 1'h0, rst_n = 1'h0;
  logic stop_instr, xtal_enabled, watchdog_timeout, watchdog_reset_en;
  logic ext_reset_event, status_read, stop_active, cpu_reset, fetch_vector;
  logic internal_oscillator_enable, osc_select, watchdog_reset_req;
  logic stop_flag, watchdog_timeout_flag, external_reset_flag;
  logic [7:0] port_pins, pin_recovery_source_enable;
  logic [15:0] vector_addr, fetched_addr;
  int num_errors = 0, check_count = 0;

  always #2.5 core_clk = ~core_clk;

  stop_mode_recovery_ctrl #(.PINS(8), .HOLD_XT(HX), .HOLD_INT(66)) uut
  (
    .core_clk(core_clk), .rst_n(rst_n), .stop_instr(stop_instr),
    .xtal_enabled(xtal_enabled), .port_pins(port_pins),
    .pin_recovery_source_enable(pin_recovery_source_enable),
    .watchdog_timeout(watchdog_timeout), .watchdog_reset_en(watchdog_reset_en),
    .ext_reset_event(ext_reset_event), .status_read(status_read),
    .stop_active(stop_active), .cpu_reset(cpu_reset), .fetch_vector(fetch_vector),
    .vector_addr(vector_addr), .internal_oscillator_enable(internal_oscillator_enable),
    .osc_select(osc_select), .watchdog_reset_req(watchdog_reset_req),
    .stop_flag(stop_flag), .watchdog_timeout_flag(watchdog_timeout_flag),
    .external_reset_flag(external_reset_flag)
  );

  smr_core_model m
  (
    .core_clk(core_clk), .fetch_vector(fetch_vector), .vector_addr(vector_addr),
    .stop_instr(stop_instr), .status_read(status_read), .port_pins(port_pins),
    .fetched_addr(fetched_addr)
  );

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic int hold_len(input logic xt);
    return xt ? HX : 66;
  endfunction

  task automatic pulse(input int which, input logic req_exp);
    @(negedge core_clk);
    if (which == 0) watchdog_timeout = 1'h1;
    else ext_reset_event = 1'h1;
    @(negedge core_clk);
    chk("wdt req", {15'h0, watchdog_reset_req}, {15'h0, req_exp});
    watchdog_timeout = 1'h0;
    ext_reset_event = 1'h0;
    @(negedge core_clk);
  endtask

  // waits for the hold, then measures it and the release
  task automatic hold_check(input int n);
    int w;
    w = 0;
    for (int i = 0; i < 8 && cpu_reset !== 1'b1; i++) @(negedge core_clk);
    while (cpu_reset === 1'b1 && w < 6000)
    begin
      w++;
      @(negedge core_clk);
    end
    chk("hold width", w[15:0], 16'(n + 1));
    chk("fetch", {15'h0, fetch_vector}, 16'h0001);
    chk("no early fetch", fetched_addr, 16'hffff);
    chk("osc sel", {15'h0, osc_select}, {15'h0, OSC_SEL_INTERNAL});
    chk("osc en", {15'h0, internal_oscillator_enable}, 16'h0001);
    @(negedge core_clk);
    chk("vector", fetched_addr, 16'h0002);
    chk("fetch end", {15'h0, fetch_vector}, 16'h0000);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic pin_round();
    int p;
    logic xt;
    p = $urandom % 8;
    xt = 1'($urandom % 2);
    xtal_enabled = xt;
    pin_recovery_source_enable = 8'h01 << p;
    pulse(1, 1'h0);
    pulse(0, 1'h1);
    chk("ext set", {15'h0, external_reset_flag}, 16'h0001);
    chk("wdt set", {15'h0, watchdog_timeout_flag}, 16'h0001);
    chk("stop clr", {15'h0, stop_flag}, 16'h0000);
    m.exec_stop();
    @(negedge core_clk);
    chk("in stop", {15'h0, stop_active}, 16'h0001);
    m.toggle_pin((p + 1) % 8);
    m.exec_stop();
    repeat (2) @(negedge core_clk);
    chk("masked pin", {15'h0, stop_active, cpu_reset}, 16'h0002);
    m.toggle_pin(p);
    hold_check(hold_len(xt));
    chk("stop flag", {15'h0, stop_flag}, 16'h0001);
    chk("wdt pin clr", {15'h0, watchdog_timeout_flag}, 16'h0000);
    chk("ext pin clr", {15'h0, external_reset_flag}, 16'h0000);
  endtask

  task automatic wdt_round();
    xtal_enabled = 1'h0;
    pin_recovery_source_enable = 8'h00;
    m.read_status();
    pulse(1, 1'h0);
    m.exec_stop();
    repeat (3) @(negedge core_clk);
    watchdog_timeout = 1'h1;
    @(negedge core_clk);
    watchdog_timeout = 1'h0;
    chk("wdt req stop", {15'h0, watchdog_reset_req}, 16'h0000);
    hold_check(66);
    chk("wdt stop", {14'h0, stop_flag, watchdog_timeout_flag}, 16'h0003);
    chk("ext kept", {15'h0, external_reset_flag}, 16'h0001);
    m.read_status();
    @(negedge core_clk);
    chk("read clr", {13'h0, stop_flag, watchdog_timeout_flag, external_reset_flag}, 16'h0);
  endtask

  initial
  begin
    xtal_enabled = 1'h0;
    watchdog_timeout = 1'h0;
    watchdog_reset_en = 1'h1;
    ext_reset_event = 1'h0;
    pin_recovery_source_enable = 8'h00;
    void'($urandom(52207));
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1'h1;
    chk("rst flags", {13'h0, stop_flag, watchdog_timeout_flag, external_reset_flag}, 16'h0);
    chk("rst osc", {15'h0, internal_oscillator_enable}, 16'h0001);
    chk("rst vec", vector_addr, RESET_VECTOR_ADDR);
    repeat (8) pin_round();
    wdt_round();
    pin_round();
    close_out();
  end

  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule
